/* verilog/rsml_top.sv */
`default_nettype none

module rsml_top
(
  // Clock, reset, enable
  input  wire  logic                                clk,
  input  wire  logic                                rst_b,
  input  wire  logic                                clk_en,
  // Strap pin input levels
  input  wire  logic                                boot_source_strap,
  input  wire  logic                                ext_irq_enable_strap,
  input  wire  logic                                link_rx_width_strap,
  // Pull selection per strap pin
  output logic [rsml_pkg::STRAP_W-1:0]              strap_pull_en,
  output logic [rsml_pkg::STRAP_W-1:0]              strap_pull_up,
  // Pins handed back to normal function
  output logic                                      pins_normal,
  // Latched strap levels
  output logic [rsml_pkg::STRAP_W-1:0]              strap_latched,
  // Boot source mode
  output logic                                      boot_from_eprom,
  output logic                                      boot_wait_external,
  // External interrupt line mode
  output logic [rsml_pkg::IRQ_LINES-1:0]            irq_enable,
  output logic [rsml_pkg::IRQ_LINES-1:0]            irq_edge_mode,
  // Link receive width code
  output logic [2:0]                                link_rx_width
);
  import rsml_pkg::*;

  // Release sequencing
  rsml_phase_t          phase;
  rsml_phase_t          next_phase;
  logic [CNT_W-1:0]     cnt;
  logic [CNT_W-1:0]     next_cnt;
  logic                 next_pins_normal;
  logic [STRAP_W-1:0]   next_pull_en;
  logic [STRAP_W-1:0]   next_pull_up;

  // Strap capture and latch
  logic [STRAP_W-1:0]   strap_pins;
  logic [STRAP_W-1:0]   sampled;
  logic [STRAP_W-1:0]   next_sampled;
  logic [STRAP_W-1:0]   next_strap_latched;
  logic                 latch_valid;
  logic                 next_latch_valid;

  // Decoder inputs and results
  logic [STRAP_W-1:0]   dec_straps;
  logic                 dec_boot_eprom;
  logic                 dec_boot_wait;
  logic [IRQ_LINES-1:0] dec_irq_en;
  logic [IRQ_LINES-1:0] dec_irq_edge;
  logic [2:0]           dec_link_w;

  // Next mode outputs
  logic                 next_boot_eprom;
  logic                 next_boot_wait;
  logic [IRQ_LINES-1:0] next_irq_en;
  logic [IRQ_LINES-1:0] next_irq_edge;
  logic [2:0]           next_link_w;

  assign strap_pins = {link_rx_width_strap, ext_irq_enable_strap, boot_source_strap};

  // Strap capture while reset is low
  always_comb
  begin
    next_sampled = sampled;
    if (!rst_b)
    begin
      next_sampled = strap_pins;
    end
  end

  // Capture register, loads on every reset edge
  // even while the enable is low
  always_ff @(posedge clk)
  begin
    if (!rst_b || clk_en)
    begin
      sampled <= next_sampled;
    end
  end

  // Release timeline in enabled edges:
  // E0 straps latched and pulls off,
  // E1 decoded modes reach the outputs,
  // E2 pins handed back to normal use.
  // Low enable stretches every step;
  // reset acts even with enable low.
  always_comb
  begin
    next_phase         = phase;
    next_cnt           = cnt;
    next_strap_latched = strap_latched;
    next_latch_valid   = latch_valid;
    next_pins_normal   = 1'b0;
    next_pull_en       = '0;
    next_pull_up       = STRAP_DEFAULT;
    case (phase)
      RSML_IN_RESET:
      begin
        // latch on first cycle after release
        next_strap_latched = sampled;
        next_phase         = RSML_RETURNING;
        next_cnt           = CNT_W'(PIN_RETURN_CYC);
        next_latch_valid   = 1'b1;
      end
      RSML_RETURNING:
      begin
        if (cnt <= CNT_W'(1))
        begin
          next_phase       = RSML_NORMAL;
          next_pins_normal = 1'b1;
          next_cnt         = '0;
        end
        else
        begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      RSML_NORMAL:
      begin
        next_pins_normal = 1'b1;
      end
      default:
      begin
        next_phase = RSML_IN_RESET;
      end
    endcase
  end

  // Phase and latch registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      phase         <= RSML_IN_RESET;
      cnt           <= '0;
      pins_normal   <= 1'b0;
      latch_valid   <= 1'b0;
      strap_pull_en <= '1;
      strap_pull_up <= STRAP_DEFAULT;
    end
    else if (clk_en)
    begin
      phase         <= next_phase;
      cnt           <= next_cnt;
      strap_latched <= next_strap_latched;
      latch_valid   <= next_latch_valid;
      pins_normal   <= next_pins_normal;
      strap_pull_en <= next_pull_en;
      strap_pull_up <= next_pull_up;
    end
  end

  // Decoder sees defaults until the first latch
  assign dec_straps = latch_valid ? strap_latched : STRAP_DEFAULT;

  // Mode decoder
  rsml_decode u_decode
  (
    .straps             (dec_straps),
    .boot_from_eprom    (dec_boot_eprom),
    .boot_wait_external (dec_boot_wait),
    .irq_enable         (dec_irq_en),
    .irq_edge_mode      (dec_irq_edge),
    .link_rx_width      (dec_link_w)
  );

  // Next mode outputs; boot stays off until a
  // latch is taken, so no stale level starts a boot
  always_comb
  begin
    next_boot_eprom = dec_boot_eprom & latch_valid;
    next_boot_wait  = dec_boot_wait & latch_valid;
    next_irq_en     = dec_irq_en;
    next_irq_edge   = dec_irq_edge;
    next_link_w     = dec_link_w;
  end

  // Registered mode outputs
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      boot_from_eprom    <= 1'b0;
      boot_wait_external <= 1'b0;
      irq_enable         <= '0;
      irq_edge_mode      <= '0;
      link_rx_width      <= LINK_W1;
    end
    else if (clk_en)
    begin
      boot_from_eprom    <= next_boot_eprom;
      boot_wait_external <= next_boot_wait;
      irq_enable         <= next_irq_en;
      irq_edge_mode      <= next_irq_edge;
      link_rx_width      <= next_link_w;
    end
  end

endmodule

`default_nettype wire

/* verilog/rsml_pkg.sv */
`default_nettype none

package rsml_pkg;

  // Strap vector layout
  localparam int unsigned STRAP_W        = 3;
  localparam int unsigned BOOT_BIT       = 0;
  localparam int unsigned IRQ_BIT        = 1;
  localparam int unsigned LINK_BIT       = 2;

  // Strap defaults, as set by the internal pulls
  localparam logic [STRAP_W-1:0] STRAP_DEFAULT = 3'h0;

  // Number of external interrupt lines
  localparam int unsigned IRQ_LINES      = 4;

  // Time from reset release until pins return to normal use
  localparam int unsigned PIN_RETURN_NS  = 16;
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned PIN_RETURN_CYC =
    (PIN_RETURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 4;

  // Link receive width codes
  localparam logic [2:0] LINK_W1 = 3'h1;
  localparam logic [2:0] LINK_W4 = 3'h4;

  // Sequencer phases
  typedef enum logic [1:0] {
    RSML_IN_RESET,
    RSML_RETURNING,
    RSML_NORMAL
  } rsml_phase_t;

endpackage

`default_nettype wire

/* verilog/rsml_decode.sv */
`default_nettype none

module rsml_decode
(
  // Captured straps
  input  wire  logic [rsml_pkg::STRAP_W-1:0]   straps,
  // Decoded modes
  output var   logic                           boot_from_eprom,
  output var   logic                           boot_wait_external,
  output var   logic [rsml_pkg::IRQ_LINES-1:0] irq_enable,
  output var   logic [rsml_pkg::IRQ_LINES-1:0] irq_edge_mode,
  output var   logic [2:0]                     link_rx_width
);
  import rsml_pkg::*;

  // Mode decode from captured levels
  always_comb
  begin
    boot_from_eprom    = ~straps[BOOT_BIT];
    boot_wait_external = straps[BOOT_BIT];
    irq_enable         = {IRQ_LINES{straps[IRQ_BIT]}};
    irq_edge_mode      = {IRQ_LINES{straps[IRQ_BIT]}};
    link_rx_width      = straps[LINK_BIT] ? LINK_W4 : LINK_W1;
  end

endmodule

`default_nettype wire

/* verification/rsml_checker.sv */
`default_nettype none
module rsml_checker
  import rsml_pkg::*;
(
  // Ports of the top block
  input wire logic clk, rst_b, clk_en,
  input wire logic boot_source_strap, ext_irq_enable_strap, link_rx_width_strap,
  input wire logic [STRAP_W-1:0] strap_pull_en, strap_pull_up, strap_latched,
  input wire logic pins_normal, boot_from_eprom, boot_wait_external,
  input wire logic [IRQ_LINES-1:0] irq_enable, irq_edge_mode,
  input wire logic [2:0] link_rx_width
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Release edge, then pins handed back
  sequence s_rel; $rose(rst_b) && clk_en; endsequence
  sequence s_back; !pins_normal [*3] ##1 pins_normal; endsequence
  property p_latch; s_rel |=> strap_latched ==
    $past({link_rx_width_strap, ext_irq_enable_strap, boot_source_strap}, 2); endproperty
  property p_pull; s_rel |-> strap_pull_en == 3'h7 && strap_pull_up == STRAP_DEFAULT; endproperty
  property p_off; s_rel |=> strap_pull_en == 3'h0; endproperty
  property p_back; s_rel |-> s_back; endproperty
  property p_boot; pins_normal |-> boot_from_eprom == !strap_latched[BOOT_BIT]
    && boot_wait_external == strap_latched[BOOT_BIT]; endproperty
  property p_irq; pins_normal |-> irq_enable == {IRQ_LINES{strap_latched[IRQ_BIT]}}
    && irq_edge_mode == irq_enable; endproperty
  property p_link; pins_normal |->
    link_rx_width == (strap_latched[LINK_BIT] ? LINK_W4 : LINK_W1); endproperty
  property p_hold; pins_normal && $past(pins_normal) |->
    $stable(strap_latched) && $stable(link_rx_width); endproperty
  a_latch: assert property (p_latch) else $error("capture");
  a_pull: assert property (p_pull) else $error("pulls");
  a_off: assert property (p_off) else $error("pulls off");
  a_back: assert property (p_back) else $error("hand back");
  a_boot: assert property (p_boot) else $error("boot");
  a_irq: assert property (p_irq) else $error("irq");
  a_link: assert property (p_link) else $error("width");
  a_hold: assert property (p_hold) else $error("hold");
endmodule
bind rsml_top rsml_checker i_rsml_checker (.*);
`default_nettype wire

/* verification/rsml_board.sv */
`default_nettype none
module rsml_board
  import rsml_pkg::*;
(
  // Pull control and bench overdrive
  input  wire logic               clk,
  input  wire logic [STRAP_W-1:0] pull_en,
  input  wire logic [STRAP_W-1:0] pull_up,
  input  wire logic [STRAP_W-1:0] ovr_en,
  input  wire logic [STRAP_W-1:0] ovr_lvl,
  output var  logic [STRAP_W-1:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [STRAP_W-1:0] noise = 3'h5;
  // Unpulled pins wander every cycle
  always @(posedge clk) noise <= ~noise;
  always_comb
    for (int i = 0; i < STRAP_W; i++)
      pins[i] = ovr_en[i] ? ovr_lvl[i] : (pull_en[i] ? pull_up[i] : noise[i]);
endmodule
`default_nettype wire

/* verification/rsml_top_tb_top.sv */
`default_nettype none
module rsml_top_tb_top;
  import rsml_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1;
  logic [2:0] ovr_en = 3'h0, ovr_lvl = 3'h0, pins, pull_en, pull_up, strap_latched;
  logic [2:0] link_rx_width;
  logic [3:0] irq_enable, irq_edge_mode;
  logic pins_normal, boot_from_eprom, boot_wait_external;
  int errors = 0, tests_run = 0;
  // 125 MHz clock
  always #4 clk = ~clk;
  rsml_top i_rsml_top (.clk, .rst_b, .clk_en, .boot_source_strap(pins[0]),
    .ext_irq_enable_strap(pins[1]), .link_rx_width_strap(pins[2]),
    .strap_pull_en(pull_en), .strap_pull_up(pull_up), .pins_normal, .strap_latched,
    .boot_from_eprom, .boot_wait_external, .irq_enable, .irq_edge_mode, .link_rx_width);
  rsml_board i_rsml_board (.clk, .pull_en, .pull_up, .ovr_en, .ovr_lvl, .pins);
  task conclude;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Reset pulse: first levels, last levels at the final reset edge, wait for hand-back
  task automatic pulse(input logic [2:0] en, first, last);
    int n = 0;
    @(posedge clk) #1;
    rst_b = 1'b0;
    ovr_en = en;
    ovr_lvl = first;
    repeat (4) @(posedge clk);
    #1 ovr_lvl = last;
    @(posedge clk) #1;
    chk(8'(pull_en), 8'h07);
    chk(8'(pull_up), 8'(STRAP_DEFAULT));
    rst_b = 1'b1;
    while (pins_normal !== 1'b1 && n < 20)
    begin
      @(posedge clk) #1;
      n++;
    end
    if (pins_normal !== 1'b1)
    begin
      errors++;
      conclude();
    end
  endtask
  task automatic modes(input logic [2:0] s);
    chk(8'(pull_en), 8'h00);
    chk(8'(strap_latched), 8'(s));
    chk(8'(boot_wait_external), 8'(s[0]));
    chk(8'(boot_from_eprom), 8'(!s[0]));
    chk(8'(irq_enable), 8'({4{s[1]}}));
    chk(8'(irq_edge_mode), 8'({4{s[1]}}));
    chk(8'(link_rx_width), 8'(s[2] ? LINK_W4 : LINK_W1));
  endtask
  task t_default;
    pulse(3'h0, 3'h7, 3'h7);
    modes(3'h0);
  endtask
  // Levels change during reset, the last one counts
  task t_all;
    pulse(3'h7, 3'h0, 3'h7);
    modes(3'h7);
  endtask
  // Pins change after release, modes must not
  task t_late;
    pulse(3'h7, 3'h5, 3'h5);
    ovr_lvl = 3'h2;
    repeat (4) @(posedge clk);
    #1;
    modes(3'h5);
  endtask
  initial
  begin
    t_default();
    t_all();
    t_late();
    conclude();
  end
endmodule
`default_nettype wire
